// [shared/plsr_regs.svh]
// Register offsets, field positions, reset values for the link status bank
// Assumes byte addressing on a 32-bit APB bus
`ifndef PLSR_REGS_SVH
`define PLSR_REGS_SVH
`define PLSR_OFF_BUS_LOC     12'h140
`define PLSR_OFF_PHY_STAT    12'h144
`define PLSR_OFF_RP_CTRL     12'h148
`define PLSR_OFF_MSI_UPPER   12'h14C
`define PLSR_OFF_IRQ_STAT    12'h180
`define PLSR_OFF_IRQ_MASK    12'h184
`define PLSR_RESET_WORD      32'h0000_0000
`define PLSR_BIT_BRIDGE_EN   0
`define PLSR_BIT_ERR_NE      16
`define PLSR_BIT_ERR_OVF     17
`define PLSR_BIT_INT_NE      18
`define PLSR_BIT_INT_OVF     19
`define PLSR_BIT_LINK_UP     11
`define PLSR_BIT_RATE_G3     12
`define PLSR_BIT_X16         13
`define PLSR_IRQ_ERR_OVF     0
`define PLSR_IRQ_INT_OVF     1
`define PLSR_IRQ_LINK_DOWN   2
`define PLSR_IRQ_W           3
`endif

// [shared/plsr_pkg.sv]
// Types shared by the link status register bank
// Assumes the constants header is included by users needing numbers
package plsr_pkg;
    // Live link status from the integrated block
    typedef struct packed {
        logic       rate_gen2;   // 5.0 GT/s
        logic       rate_gen3;   // 8.0 GT/s, overrides gen2
        logic [1:0] width;       // x1..x8
        logic       width_x16;   // Overrides width
        logic [5:0] ltssm;       // Training state
        logic       link_up;     // In L0
    } plsr_phy_t;
    // Location reported by enumeration
    typedef struct packed {
        logic [7:0] bus;         // Bus number
        logic [4:0] dev;         // Device number
    } plsr_loc_t;
    // Queue status from the root port message queues
    typedef struct packed {
        logic err_not_empty;     // Error queue holds entry
        logic err_drop;          // Error message dropped, pulse
        logic int_not_empty;     // Interrupt queue holds entry
        logic int_drop;          // Interrupt message dropped, pulse
    } plsr_fifo_t;
    // APB request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } plsr_apb_req_t;
endpackage

// [hw/plsr_apb_slave.sv]
// Zero-wait APB slave front end: decodes one access per transfer
// Assumes the bus master follows APB setup then access phase
`timescale 1ns/1ps
`default_nettype none
module plsr_apb_slave
    import plsr_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire plsr_apb_req_t req,
    output logic               wr_en,
    output logic               rd_en,
    output logic [11:0]        addr
);
    ////////////////////////////////////////////////////////////////////////
    // Access phase is the completing one while ce holds pready high; ce low stretches it
    assign wr_en = req.psel & req.penable & req.pwrite;
    assign rd_en = req.psel & ~req.penable & ~req.pwrite;
    assign addr  = {req.paddr[11:2], 2'h0};
endmodule
`default_nettype wire

// [hw/plsr_edge_fall.sv]
// Falling-edge detector for a synchronous level
// Assumes the input is already in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module plsr_edge_fall
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic level,
    output logic      fell
);
    logic level_q;    // Previous sample
    ////////////////////////////////////////////////////////////////////////
    // Remember last level; frozen with clock enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level_q <= 1'b0;
        else if (ce)
            level_q <= level;
    end
    assign fell = ce & level_q & ~level;
endmodule
`default_nettype wire

// [hw/plsr_top.sv]
// Link status, location, root port control and upper MSI address registers
// Assumes one pclk domain; status inputs are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "plsr_regs.svh"
module plsr_top
    import plsr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        root_port_mode,
    input  wire logic        msi_64bit,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire plsr_phy_t   phy,
    input  wire plsr_loc_t   loc,
    input  wire plsr_fifo_t  fifo,
    input  wire logic        axi_side_address_window_req,
    output logic             axi_side_address_window_pass,
    output logic             bridge_enable,
    output logic [7:0]       port_number,
    output logic [31:0]      msi_address_upper,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    plsr_apb_req_t req;              // Bundled bus request
    logic          wr_en;            // Write completes this cycle
    logic          rd_en;            // Setup of a read
    logic [11:0]   addr;             // Word-aligned address
    logic          link_fell;        // Link went up to down
    logic [7:0]    port_q;           // Port number
    logic          bren_q;           // Bridge enable
    logic          err_ovf_q;        // Error drop sticky
    logic          int_ovf_q;        // Interrupt drop sticky
    logic [31:0]   msi_q;            // Upper MSI address
    logic [`PLSR_IRQ_W-1:0] ist_q;   // Interrupt status
    logic [`PLSR_IRQ_W-1:0] imask_q; // Interrupt mask
    logic [`PLSR_IRQ_W-1:0] iev;     // Events this cycle
    logic [31:0]   rdata_d;          // Read mux
    logic          hit_d;            // Mapped address

    assign req = '{psel, penable, pwrite, paddr, pwdata};

    // Write one to clear, set wins over clear
    function automatic logic w1c(input logic cur, input logic set,
                                 input logic clr);
        w1c = set | (cur & ~clr);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    plsr_apb_slave u_apb
    (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (req),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .addr    (addr)
    );

    plsr_edge_fall u_fall
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .level   (phy.link_up),
        .fell    (link_fell)
    );

    ////////////////////////////////////////////////////////////////////////
    // Port number: endpoint ignores writes and reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_q <= 8'h00;
        else if (ce)
        begin
            if (!root_port_mode)
                port_q <= 8'h00;
            else if (wr_en && addr == `PLSR_OFF_BUS_LOC && pstrb[2])
                port_q <= pwdata[23:16];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bridge enable; link loss beats a software set in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bren_q <= 1'b0;
        else if (ce)
        begin
            if (!root_port_mode || link_fell)
                bren_q <= 1'b0;
            else if (wr_en && addr == `PLSR_OFF_RP_CTRL && pstrb[0])
                bren_q <= pwdata[`PLSR_BIT_BRIDGE_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Queue overflow stickies; drops only counted in root port mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_ovf_q <= 1'b0;
            int_ovf_q <= 1'b0;
        end
        else if (ce)
        begin
            err_ovf_q <= root_port_mode & w1c(err_ovf_q, fifo.err_drop,
                wr_en && addr == `PLSR_OFF_RP_CTRL && pstrb[2]
                && pwdata[`PLSR_BIT_ERR_OVF]);
            int_ovf_q <= root_port_mode & w1c(int_ovf_q, fifo.int_drop,
                wr_en && addr == `PLSR_OFF_RP_CTRL && pstrb[2]
                && pwdata[`PLSR_BIT_INT_OVF]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Upper MSI address, byte-lane writes, root port only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            msi_q <= `PLSR_RESET_WORD;
        else if (ce)
        begin
            if (!root_port_mode)
                msi_q <= `PLSR_RESET_WORD;
            else if (wr_en && addr == `PLSR_OFF_MSI_UPPER)
            begin
                for (int b = 0; b < 4; b++)
                    if (pstrb[b])
                        msi_q[8*b +: 8] <= pwdata[8*b +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    assign iev = {link_fell, fifo.int_drop & root_port_mode,
                  fifo.err_drop & root_port_mode};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_q   <= '0;
            imask_q <= '0;
        end
        else if (ce)
        begin
            for (int i = 0; i < `PLSR_IRQ_W; i++)
                ist_q[i] <= w1c(ist_q[i], iev[i],
                    wr_en && addr == `PLSR_OFF_IRQ_STAT && pstrb[0]
                    && pwdata[i]);
            if (wr_en && addr == `PLSR_OFF_IRQ_MASK && pstrb[0])
                imask_q <= pwdata[`PLSR_IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits are zero by construction
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        unique case (addr)
            `PLSR_OFF_BUS_LOC:
                rdata_d = {8'h00, port_q, loc.bus, loc.dev,
                           3'h0};
            `PLSR_OFF_PHY_STAT:
            begin
                rdata_d[0]   = phy.rate_gen2;
                rdata_d[2:1] = phy.width;
                rdata_d[8:3] = phy.ltssm;
                rdata_d[`PLSR_BIT_LINK_UP]  = phy.link_up;
                rdata_d[`PLSR_BIT_RATE_G3]  = phy.rate_gen3;
                rdata_d[`PLSR_BIT_X16]      = phy.width_x16;
            end
            `PLSR_OFF_RP_CTRL:
                if (root_port_mode)
                begin
                    rdata_d[`PLSR_BIT_BRIDGE_EN] = bren_q;
                    rdata_d[`PLSR_BIT_ERR_NE]  = fifo.err_not_empty;
                    rdata_d[`PLSR_BIT_ERR_OVF] = err_ovf_q;
                    rdata_d[`PLSR_BIT_INT_NE]  = fifo.int_not_empty;
                    rdata_d[`PLSR_BIT_INT_OVF] = int_ovf_q;
                end
            `PLSR_OFF_MSI_UPPER:
                rdata_d = msi_64bit ? msi_q : 32'h0000_0000;
            `PLSR_OFF_IRQ_STAT:
                rdata_d[`PLSR_IRQ_W-1:0] = ist_q;
            `PLSR_OFF_IRQ_MASK:
                rdata_d[`PLSR_IRQ_W-1:0] = imask_q;
            default:
                hit_d = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer registered in setup, so pready holds high in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce && psel && !penable)
        begin
            prdata  <= rd_en ? rdata_d : 32'h0000_0000;
            pslverr <= ~hit_d;
        end
    end

    // Ready: registered high once out of reset; ce low stalls the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= ce;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            axi_side_address_window_pass <= 1'b0;
            bridge_enable     <= 1'b0;
            port_number       <= 8'h00;
            msi_address_upper <= 32'h0000_0000;
            irq               <= 1'b0;
        end
        else if (ce)
        begin
            axi_side_address_window_pass <=
                axi_side_address_window_req & bren_q;
            bridge_enable     <= bren_q;
            port_number       <= port_q;
            msi_address_upper <= msi_q;
            irq               <= |(ist_q & imask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_link_down_clr: assert property (@(posedge pclk) disable iff (!presetn)
        ce && link_fell |=> !bren_q)
        else $error("bridge enable survived link down");
    a_pass_gated: assert property (@(posedge pclk) disable iff (!presetn)
        axi_side_address_window_pass |-> $past(bren_q))
        else $error("window passed while bridge disabled");
    a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ce && root_port_mode && fifo.err_drop |=> err_ovf_q)
        else $error("error drop not recorded");
    a_int_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ce && root_port_mode && fifo.int_drop |=> int_ovf_q)
        else $error("interrupt drop not recorded");
    a_err_hold: assert property (@(posedge pclk) disable iff (!presetn)
        err_ovf_q && ce && root_port_mode && !wr_en |=> err_ovf_q)
        else $error("error sticky lost without a clear");
    a_port_ep_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !root_port_mode |=> port_q == 8'h00)
        else $error("port number nonzero in endpoint");
    a_msi_ep_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !root_port_mode |=> msi_q == 32'h0000_0000)
        else $error("upper MSI held in endpoint");
    a_rp_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && !root_port_mode && addr == `PLSR_OFF_RP_CTRL
        |-> rdata_d == 32'h0000_0000)
        else $error("root port register visible in endpoint");
    a_loc_func: assert property (@(posedge pclk) disable iff (!presetn)
        addr == `PLSR_OFF_BUS_LOC |-> rdata_d[2:0] == 3'h0)
        else $error("function number not zero");
    a_msi32_zero: assert property (@(posedge pclk) disable iff (!presetn)
        addr == `PLSR_OFF_MSI_UPPER && !msi_64bit
        |-> rdata_d == 32'h0000_0000)
        else $error("upper MSI visible in 32-bit mode");
endmodule
`default_nettype wire

// [verification/plsr_top_tb_top.sv]
// Self-checking bench for the link status register bank, driven over APB
// Assumes plsr_pkg and plsr_regs.svh are on the compile path
`timescale 1ns/1ps
`default_nettype none
`include "plsr_regs.svh"
`define CHK(nm, ex, got) \
    begin \
        checks = checks + 1; \
        if ((got) !== (ex)) \
        begin \
            err_count = err_count + 1; \
            $display("wrong value %s exp %h got %h", nm, ex, got); \
        end \
    end
module plsr_top_tb_top
    import plsr_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    logic        pclk;            // 250 MHz bus clock
    logic        presetn;         // Async reset, active low
    logic        ce;              // Clock enable, dropped once to freeze
    logic        root_port_mode;  // 1 = root port build
    logic        msi_64bit;       // 1 = 64-bit MSI in use
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    plsr_phy_t   phy;             // Live link status
    plsr_loc_t   loc;             // Enumerated location
    plsr_fifo_t  fifo;            // Queue flags and drop pulses
    logic        win_req;         // Outbound window request
    logic        win_pass;        // Request let through
    logic        bridge_enable;
    logic [7:0]  port_number;
    logic [31:0] msi_upper;
    logic        irq;
    int          err_count;       // Mismatches seen
    int          checks;          // Comparisons made
    logic [31:0] rd;              // Data taken at the last access edge
    logic        serr;            // Error flag taken at the same edge
    // Link status stimulus: gen2, gen3, both, wide, x16, width 10
    logic [11:0] pv [6] = '{12'h800, 12'h500, 12'hC00, 12'h37E, 12'h081,
                            12'h2A3};

    ////////////////////////////////////////////////////////////////////////
    plsr_top uut
    (
        .pclk                         (pclk),
        .presetn                      (presetn),
        .ce                           (ce),
        .root_port_mode               (root_port_mode),
        .msi_64bit                    (msi_64bit),
        .psel                         (psel),
        .penable                      (penable),
        .pwrite                       (pwrite),
        .paddr                        (paddr),
        .pwdata                       (pwdata),
        .pstrb                        (pstrb),
        .prdata                       (prdata),
        .pready                       (pready),
        .pslverr                      (pslverr),
        .phy                          (phy),
        .loc                          (loc),
        .fifo                         (fifo),
        .axi_side_address_window_req  (win_req),
        .axi_side_address_window_pass (win_pass),
        .bridge_enable                (bridge_enable),
        .port_number                  (port_number),
        .msi_address_upper            (msi_upper),
        .irq                          (irq)
    );

    // Free-running clock, 4 ns period
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run; also reached when a wait runs out
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_count = err_count + 1;
            close_out();
        end
        rd      = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Full-word write
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    // Read and compare with an expected word
    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] ex);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        `CHK(nm, ex, rd)
    endtask

    // Let registered outputs catch up
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Expected link status word, built field by field
    function automatic logic [31:0] phy_word(input plsr_phy_t p);
        phy_word = {18'h0, p.width_x16, p.rate_gen3, p.link_up, 2'b00,
                    p.ltssm, p.width, p.rate_gen2};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        err_count = 0;
        checks = 0;
        presetn = 1'b0;
        ce = 1'b1;
        root_port_mode = 1'b1;
        msi_64bit = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        phy = '0;
        loc = '0;
        fifo = '0;
        win_req = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Location, root port control and upper MSI read zero after reset
        rd_chk("bus_location", `PLSR_OFF_BUS_LOC, 32'h0);
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h0);
        rd_chk("msi_upper", `PLSR_OFF_MSI_UPPER, 32'h0);
        $display("test reset done");
        // Location: read-only fields track inputs, port number writable
        loc <= '{bus: 8'hA5, dev: 5'h13};
        wr32(`PLSR_OFF_BUS_LOC, 32'hFFFF_FFFF);
        rd_chk("bus_location", `PLSR_OFF_BUS_LOC, 32'h00FF_A598);
        `CHK("port_number", 8'hFF, port_number)
        // Lane 2 strobe off leaves the port number alone
        xfer(1'b1, `PLSR_OFF_BUS_LOC, 32'h0012_0000, 4'hB);
        loc <= '{bus: 8'h3C, dev: 5'h07};
        rd_chk("bus_location", `PLSR_OFF_BUS_LOC, 32'h00FF_3C38);
        $display("test location done");
        // Link status fields, including rate and width overrides
        for (int i = 0; i < 6; i++)
        begin
            phy <= plsr_phy_t'(pv[i]);
            wr32(`PLSR_OFF_PHY_STAT, 32'hFFFF_FFFF);
            rd_chk("phy_status", `PLSR_OFF_PHY_STAT,
                   phy_word(plsr_phy_t'(pv[i])));
        end
        $display("test link status done");
        // Bridge enable gates the outbound window
        win_req <= 1'b1;
        tick(2);
        `CHK("window_pass", 1'b0, win_pass)
        wr32(`PLSR_OFF_RP_CTRL, 32'hFFFF_FFFF);
        tick(2);
        `CHK("bridge_enable", 1'b1, bridge_enable)
        `CHK("window_pass", 1'b1, win_pass)
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h1);
        // Queue flags and sticky drops; writing zero clears nothing
        fifo <= plsr_fifo_t'(4'hF);
        tick(1);
        fifo <= plsr_fifo_t'(4'hA);
        tick(2);
        wr32(`PLSR_OFF_RP_CTRL, 32'h0000_0001);
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h000F_0001);
        wr32(`PLSR_OFF_RP_CTRL, 32'h0002_0001);
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h000D_0001);
        wr32(`PLSR_OFF_RP_CTRL, 32'h0008_0001);
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h0005_0001);
        fifo <= plsr_fifo_t'(4'h0);
        tick(2);
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h0000_0001);
        // Drop events raised, masked, then cleared
        rd_chk("irq_status", `PLSR_OFF_IRQ_STAT, 32'h3);
        `CHK("irq", 1'b0, irq)
        wr32(`PLSR_OFF_IRQ_MASK, 32'h1);
        tick(2);
        `CHK("irq", 1'b1, irq)
        wr32(`PLSR_OFF_IRQ_STAT, 32'h3);
        tick(2);
        `CHK("irq", 1'b0, irq)
        $display("test root port control done");
        // Link falling clears the bridge enable and flags an event
        phy.link_up <= 1'b0;
        tick(3);
        `CHK("bridge_enable", 1'b0, bridge_enable)
        `CHK("window_pass", 1'b0, win_pass)
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h0);
        rd_chk("irq_status", `PLSR_OFF_IRQ_STAT, 32'h4);
        wr32(`PLSR_OFF_IRQ_MASK, 32'h4);
        tick(2);
        `CHK("irq", 1'b1, irq)
        wr32(`PLSR_OFF_IRQ_STAT, 32'h4);
        tick(2);
        `CHK("irq", 1'b0, irq)
        $display("test link down done");
        // Upper MSI address, hidden when 32-bit MSI is in use
        wr32(`PLSR_OFF_MSI_UPPER, 32'hDEAD_BEEF);
        rd_chk("msi_upper", `PLSR_OFF_MSI_UPPER, 32'hDEAD_BEEF);
        `CHK("pslverr", 1'b0, serr)
        `CHK("msi_out", 32'hDEAD_BEEF, msi_upper)
        msi_64bit <= 1'b0;
        rd_chk("msi_upper", `PLSR_OFF_MSI_UPPER, 32'h0);
        msi_64bit <= 1'b1;
        // Unmapped address answers with an error and zero data
        xfer(1'b0, 12'h1F0, 32'h0, 4'h0);
        `CHK("unmapped_data", 32'h0, rd)
        `CHK("unmapped_err", 1'b1, serr)
        $display("test msi and unmapped done");
        // Clock enable low freezes state: a drop pulse is not recorded
        ce <= 1'b0;
        fifo <= plsr_fifo_t'(4'h4);
        tick(1);
        fifo <= plsr_fifo_t'(4'h0);
        tick(2);
        `CHK("pready_frozen", 1'b0, pready)
        ce <= 1'b1;
        rd_chk("irq_status", `PLSR_OFF_IRQ_STAT, 32'h0);
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h0);
        $display("test clock enable done");
        // Endpoint build: root port registers vanish, port reads zero
        root_port_mode <= 1'b0;
        wr32(`PLSR_OFF_BUS_LOC, 32'h00AA_0000);
        rd_chk("bus_location", `PLSR_OFF_BUS_LOC, 32'h0000_3C38);
        wr32(`PLSR_OFF_RP_CTRL, 32'h0000_0001);
        rd_chk("root_port_ctrl", `PLSR_OFF_RP_CTRL, 32'h0);
        tick(2);
        `CHK("bridge_enable", 1'b0, bridge_enable)
        rd_chk("msi_upper", `PLSR_OFF_MSI_UPPER, 32'h0);
        $display("test endpoint done");
        close_out();
    end
endmodule
`default_nettype wire
